// ===== rtl/dacs_pkg.sv
// Purpose: Shared constants for the dual converter sequencer and its controller
// Assumes: One clock, core_clk_i at 10 MHz, drives both ends
// Notes: Behaviour
// Behaviour
// - Strobe rise puts both capacitors in hold
// - Conversion begins at the next rising clock
// - Controller never strobes while busy is high
// - Device samples read strobe on falling edges
// - Tied strobes: raise at rising edge, convert next
// - Conversion takes exactly twelve clocks
// - One precharge clock, then inputs reconnect
// - Starts spaced at least sixteen clocks apart
// - Busy stays low during acquisition
// - Both converters sample and convert together
// - Differential: code 00 pair0, 11 pair1
// - Pseudo: 00 p0+, 01 p1-, 11 p1+
// - Action code reset performs a full reset
// - Hold ten-bit reference DAC code
// - Reference power-down bit disables internal reference
// - DAC code defaults to the 2.5V value
// - Controller avoids DAC codes below 0.5V; dacs_ctl sends any code, DAC_MIN_CODE is not checked
// - Busy rises at hold, falls after conversion
// - Twelve-bit word, MSB first, falling edges
// - New settings act at twelfth rising edge
package dacs_pkg;
   localparam int CFG_BITS = 12;
   localparam int RES_BITS = 12;
   localparam int DAC_BITS = 10;
   localparam int CONV_CLKS = 12;
   localparam int PRECHARGE_CLKS = 1;
   localparam int MIN_CYCLE_CLKS = 16;
   localparam int CLK_PERIOD_NS = 100;
   // Configuration word layout
   localparam int CFG_SEL_HI = 11;
   localparam int CFG_SEL_LO = 10;
   localparam int CFG_RP = 4;
   localparam int CFG_ACT_HI = 2;
   localparam int CFG_ACT_LO = 0;
   localparam logic [11:0] CFG_DEFAULT = 12'h000;
   localparam logic [2:0] ACT_DAC_WR = 3'h1;
   localparam logic [2:0] ACT_RESET = 3'h5;
   // Reference DAC
   localparam int REF_DEFAULT_UV = 2500000;
   localparam int DAC_STEP_UV = 2440;
   localparam int REF_MIN_UV = 500000;
   localparam int DAC_CODE_CALC = REF_DEFAULT_UV / DAC_STEP_UV;
   localparam int DAC_CODE_MAXI = (1 << DAC_BITS) - 1;
   // The 2.5V point sits just past full scale, so the top code is used
   localparam logic [9:0] DAC_DEFAULT =
      10'((DAC_CODE_CALC > DAC_CODE_MAXI) ? DAC_CODE_MAXI : DAC_CODE_CALC);
   localparam logic [9:0] DAC_MIN_CODE = 10'((REF_MIN_UV + DAC_STEP_UV - 1) / DAC_STEP_UV);
   // Multiplexer routing codes
   localparam logic [1:0] POS_P0P = 2'h0;
   localparam logic [1:0] POS_P1N = 2'h1;
   localparam logic [1:0] POS_P1P = 2'h2;
   localparam logic NEG_P0N = 1'b0;
   localparam logic NEG_P1N = 1'b1;
   // Controller registers
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_CFG = 2'h1;
   localparam logic [1:0] REG_STAT = 2'h2;
   localparam int CTRL_START = 0;
   localparam int CTRL_TIED = 1;
   localparam int CTRL_SEND = 2;
   localparam logic [15:0] RD_UNMAPPED = 16'h0000;
endpackage

// ===== rtl/dacs_link_if.sv
// Purpose: Pins between the converter sequencer and its controller
// Assumes: Both ends run on the same clock
// Notes: All pins are one-way, no enables needed
`timescale 1ns/1ns
`default_nettype none
interface dacs_link_if;
   logic hold_start_strobe;
   logic read_strobe;
   logic serial_config_input;
   logic busy;
   modport dev (
      input hold_start_strobe,
      input read_strobe,
      input serial_config_input,
      output busy
   );
   modport ctl (
      output hold_start_strobe,
      output read_strobe,
      output serial_config_input,
      input busy
   );
endinterface
`default_nettype wire

// ===== rtl/dacs_dev.sv
// Purpose: Conversion sequencer of a dual simultaneous-sampling SAR converter
// Assumes: Controller logic on the same clock drives the link pins
// Notes: Analog inputs arrive as digital levels; hold freezes them
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module dacs_dev #(
   parameter int RES_W = dacs_pkg::RES_BITS,
   parameter int CONV_N = dacs_pkg::CONV_CLKS
) (
   // Clock, reset, enable
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Link
   dacs_link_if.dev link,
   // Analog side
   input wire logic pseudo_diff_i,
   input wire logic [RES_W-1:0] sample_a_i,
   input wire logic [RES_W-1:0] sample_b_i,
   output logic hold_o,
   output logic precharge_o,
   output logic [1:0] pos_sel_o,
   output logic neg_sel_o,
   output logic ref_pd_o,
   output logic [9:0] dac_code_o,
   // Results
   output logic [RES_W-1:0] result_a_o,
   output logic [RES_W-1:0] result_b_o,
   output logic result_valid_o
);
   initial begin
      if (RES_W != CONV_N || RES_W < 2 || RES_W > 16) begin
         $error("one conversion clock per result bit, 2 to 16 bits");
      end
   end

   typedef enum logic [3:0] {
      S_TRACK = 4'b0001,
      S_HOLD = 4'b0010,
      S_CONV = 4'b0100,
      S_PRE = 4'b1000
   } dacs_state_e;

   function automatic logic [RES_W-1:0] sar_step(input logic [RES_W-1:0] held,
                                                  input logic [RES_W-1:0] approx,
                                                  input logic [3:0] bit_i);
      logic [RES_W-1:0] trial;
      trial = approx | (RES_W'(1) << bit_i);
      sar_step = (held >= trial) ? trial : approx;
   endfunction

   // Serial configuration capture on falling edges
   logic [3:0] sh_cnt_reg, sh_cnt_next;
   logic [11:0] sh_reg, sh_next;
   logic sh_tog_reg, sh_tog_next;

   always_comb begin
      sh_cnt_next = sh_cnt_reg;
      sh_reg_next_blk: begin
         sh_next = sh_reg;
      end
      sh_tog_next = sh_tog_reg;
      if (link.read_strobe) begin
         sh_next = {11'h000, link.serial_config_input};
         sh_cnt_next = 4'h1;
      end else if (sh_cnt_reg != 4'h0) begin
         sh_next = {sh_reg[10:0], link.serial_config_input};
         sh_cnt_next = sh_cnt_reg + 4'h1;
      end
      if (sh_cnt_next == 4'(dacs_pkg::CFG_BITS)) begin
         sh_cnt_next = 4'h0;
         sh_tog_next = ~sh_tog_reg;
      end
   end

   always_ff @(negedge core_clk_i) begin
      if (!rst_b_i) begin
         sh_cnt_reg <= 4'h0;
         sh_reg <= 12'h000;
         sh_tog_reg <= 1'b0;
      end else if (ce_i) begin
         sh_cnt_reg <= sh_cnt_next;
         sh_reg <= sh_next;
         sh_tog_reg <= sh_tog_next;
      end
   end

   // Configuration and sequencer on rising edges
   dacs_state_e state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   logic strobe_q_reg, strobe_q_next;
   logic tog_seen_reg, tog_seen_next;
   logic [11:0] cfg_reg, cfg_next;
   logic dac_pend_reg, dac_pend_next;
   logic [9:0] dac_reg, dac_next;
   logic [RES_W-1:0] held_a_reg, held_a_next, held_b_reg, held_b_next;
   logic [RES_W-1:0] sar_a_reg, sar_a_next, sar_b_reg, sar_b_next;
   logic [RES_W-1:0] res_a_reg, res_a_next, res_b_reg, res_b_next;
   logic valid_reg, valid_next;
   logic hold_reg, hold_next, pre_reg, pre_next, busy_reg, busy_next;
   logic [1:0] pos_reg, pos_next;
   logic neg_reg, neg_next;
   logic new_word, do_reset;
   logic [1:0] sel;

   assign new_word = sh_tog_reg != tog_seen_reg;
   assign do_reset = new_word && !dac_pend_reg
                     && sh_reg[dacs_pkg::CFG_ACT_HI:dacs_pkg::CFG_ACT_LO] == dacs_pkg::ACT_RESET;
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      strobe_q_next = link.hold_start_strobe;
      tog_seen_next = sh_tog_reg;
      cfg_next = cfg_reg;
      dac_pend_next = dac_pend_reg;
      dac_next = dac_reg;
      held_a_next = held_a_reg;
      held_b_next = held_b_reg;
      sar_a_next = sar_a_reg;
      sar_b_next = sar_b_reg;
      res_a_next = res_a_reg;
      res_b_next = res_b_reg;
      valid_next = 1'b0;
      hold_next = hold_reg;
      pre_next = pre_reg;
      busy_next = busy_reg;
      pos_next = pos_reg;
      neg_next = neg_reg;
      // Settings land one rising edge after the twelfth falling edge
      if (new_word) begin
         if (dac_pend_reg) begin
            dac_next = sh_reg[9:0];
            dac_pend_next = 1'b0;
         end else if (!do_reset) begin
            cfg_next = sh_reg;
            dac_pend_next = sh_reg[dacs_pkg::CFG_ACT_HI:dacs_pkg::CFG_ACT_LO] == dacs_pkg::ACT_DAC_WR;
         end
      end
      // Routing follows the incoming select code so it lands with the word, fixed while in hold
      sel = cfg_next[dacs_pkg::CFG_SEL_HI:dacs_pkg::CFG_SEL_LO];
      if (!hold_reg) begin
         neg_next = dacs_pkg::NEG_P0N;
         case (sel)
            2'b00: pos_next = dacs_pkg::POS_P0P;
            2'b01: pos_next = dacs_pkg::POS_P1N;
            2'b10: pos_next = dacs_pkg::POS_P1P;
            default: begin
               pos_next = dacs_pkg::POS_P1P;
               neg_next = pseudo_diff_i ? dacs_pkg::NEG_P0N : dacs_pkg::NEG_P1N;
            end
         endcase
      end
      case (state_reg)
         S_TRACK: begin
            // A strobe while busy is ignored; the controller must not send one
            if (link.hold_start_strobe && !strobe_q_reg) begin
               state_next = S_HOLD;
               hold_next = 1'b1;
               busy_next = 1'b1;
               held_a_next = sample_a_i;
               held_b_next = sample_b_i;
            end else begin
               busy_next = 1'b0;
            end
         end
         S_HOLD: begin
            state_next = S_CONV;
            cnt_next = 4'(CONV_N - 1);
            sar_a_next = '0;
            sar_b_next = '0;
         end
         S_CONV: begin
            sar_a_next = sar_step(held_a_reg, sar_a_reg, cnt_reg);
            sar_b_next = sar_step(held_b_reg, sar_b_reg, cnt_reg);
            cnt_next = cnt_reg - 4'h1;
            if (cnt_reg == 4'h0) begin
               state_next = S_PRE;
               cnt_next = 4'(dacs_pkg::PRECHARGE_CLKS - 1);
               pre_next = 1'b1;
               res_a_next = sar_step(held_a_reg, sar_a_reg, cnt_reg);
               res_b_next = sar_step(held_b_reg, sar_b_reg, cnt_reg);
               valid_next = 1'b1;
            end
         end
         S_PRE: begin
            cnt_next = cnt_reg - 4'h1;
            if (cnt_reg == 4'h0) begin
               state_next = S_TRACK;
               pre_next = 1'b0;
               hold_next = 1'b0;
               busy_next = 1'b0;
            end
         end
         default: begin
            state_next = S_TRACK;
            hold_next = 1'b0;
            pre_next = 1'b0;
            busy_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || (ce_i && do_reset)) begin
         state_reg <= S_TRACK;
         cnt_reg <= 4'h0;
         strobe_q_reg <= 1'b1;
         tog_seen_reg <= rst_b_i ? sh_tog_reg : 1'b0;
         cfg_reg <= dacs_pkg::CFG_DEFAULT;
         dac_pend_reg <= 1'b0;
         dac_reg <= dacs_pkg::DAC_DEFAULT;
         held_a_reg <= '0;
         held_b_reg <= '0;
         sar_a_reg <= '0;
         sar_b_reg <= '0;
         res_a_reg <= '0;
         res_b_reg <= '0;
         valid_reg <= 1'b0;
         hold_reg <= 1'b0;
         pre_reg <= 1'b0;
         busy_reg <= 1'b0;
         pos_reg <= dacs_pkg::POS_P0P;
         neg_reg <= dacs_pkg::NEG_P0N;
      end else if (ce_i) begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         strobe_q_reg <= strobe_q_next;
         tog_seen_reg <= tog_seen_next;
         cfg_reg <= cfg_next;
         dac_pend_reg <= dac_pend_next;
         dac_reg <= dac_next;
         held_a_reg <= held_a_next;
         held_b_reg <= held_b_next;
         sar_a_reg <= sar_a_next;
         sar_b_reg <= sar_b_next;
         res_a_reg <= res_a_next;
         res_b_reg <= res_b_next;
         valid_reg <= valid_next;
         hold_reg <= hold_next;
         pre_reg <= pre_next;
         busy_reg <= busy_next;
         pos_reg <= pos_next;
         neg_reg <= neg_next;
      end
   end

   assign link.busy = busy_reg;
   assign hold_o = hold_reg;
   assign precharge_o = pre_reg;
   assign pos_sel_o = pos_reg;
   assign neg_sel_o = neg_reg;
   assign ref_pd_o = cfg_reg[dacs_pkg::CFG_RP];
   assign dac_code_o = dac_reg;
   assign result_a_o = res_a_reg;
   assign result_b_o = res_b_reg;
   assign result_valid_o = valid_reg;
endmodule // dacs_dev
`default_nettype wire

// ===== rtl/dacs_ctl.sv
// Purpose: Controller end: strobes conversions and shifts configuration words
// Assumes: Software uses the plain register port; one clock with the device
// Notes: A start waits for the minimum spacing and for busy low
`timescale 1ns/1ns
`default_nettype none
module dacs_ctl #(
   parameter int GAP_N = dacs_pkg::MIN_CYCLE_CLKS
) (
   // Clock, reset, enable
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Register port
   input wire logic [1:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   // Link
   dacs_link_if.ctl link
);
   initial begin
      if (GAP_N < dacs_pkg::MIN_CYCLE_CLKS || GAP_N > 31) begin
         $error("start spacing must be 16 to 31 clocks");
      end
   end

   typedef enum logic [1:0] {
      H_IDLE = 2'b01,
      H_SHIFT = 2'b10
   } dacs_hstate_e;

   dacs_hstate_e st_reg, st_next;
   logic [11:0] cfg_reg, cfg_next, sh_reg, sh_next;
   logic [3:0] bits_reg, bits_next;
   logic [4:0] gap_reg, gap_next;
   logic tied_reg, tied_next, start_reg, start_next, send_reg, send_next;
   logic strobe_reg, strobe_next, rdstb_reg, rdstb_next, sdi_reg, sdi_next;
   logic [15:0] rdata_reg, rdata_next;
   logic wr_ctrl, launch, shift_go;

   assign wr_ctrl = wr_i && addr_i == dacs_pkg::REG_CTRL;
   // Spacing and busy guard every start
   assign launch = st_reg == H_IDLE && start_reg && gap_reg == 5'h00 && !link.busy;
   assign shift_go = st_reg == H_IDLE && ((launch && tied_reg) || (!launch && !start_reg && send_reg));

   always_comb begin
      st_next = st_reg;
      cfg_next = cfg_reg;
      sh_next = sh_reg;
      bits_next = bits_reg;
      gap_next = (gap_reg != 5'h00) ? gap_reg - 5'h01 : gap_reg;
      tied_next = tied_reg;
      start_next = start_reg && !launch;
      send_next = send_reg && !shift_go;
      strobe_next = 1'b0;
      rdstb_next = 1'b0;
      sdi_next = 1'b0;
      rdata_next = dacs_pkg::RD_UNMAPPED;
      if (wr_ctrl) begin
         start_next = start_next || wdata_i[dacs_pkg::CTRL_START];
         send_next = send_next || wdata_i[dacs_pkg::CTRL_SEND];
         tied_next = wdata_i[dacs_pkg::CTRL_TIED];
      end
      if (wr_i && addr_i == dacs_pkg::REG_CFG) begin
         cfg_next = wdata_i[11:0];
      end
      if (launch) begin
         strobe_next = 1'b1;
         gap_next = 5'(GAP_N - 1);
      end
      case (st_reg)
         H_IDLE: begin
            if (shift_go) begin
               rdstb_next = 1'b1;
               sdi_next = cfg_reg[11];
               sh_next = {cfg_reg[10:0], 1'b0};
               bits_next = 4'(dacs_pkg::CFG_BITS - 2);
               st_next = H_SHIFT;
            end
         end
         H_SHIFT: begin
            sdi_next = sh_reg[11];
            sh_next = {sh_reg[10:0], 1'b0};
            bits_next = bits_reg - 4'h1;
            if (bits_reg == 4'h0) begin
               st_next = H_IDLE;
            end
         end
         default: begin
            st_next = H_IDLE;
         end
      endcase
      if (rd_i) begin
         case (addr_i)
            dacs_pkg::REG_CTRL: rdata_next = {13'h0000, send_reg, tied_reg, start_reg};
            dacs_pkg::REG_CFG: rdata_next = {4'h0, cfg_reg};
            dacs_pkg::REG_STAT: rdata_next = {11'h000, gap_reg == 5'h00, st_reg == H_SHIFT, 2'b00, link.busy};
            default: rdata_next = dacs_pkg::RD_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         st_reg <= H_IDLE;
         cfg_reg <= dacs_pkg::CFG_DEFAULT;
         sh_reg <= 12'h000;
         bits_reg <= 4'h0;
         gap_reg <= 5'h00;
         tied_reg <= 1'b0;
         start_reg <= 1'b0;
         send_reg <= 1'b0;
         strobe_reg <= 1'b0;
         rdstb_reg <= 1'b0;
         sdi_reg <= 1'b0;
         rdata_reg <= 16'h0000;
      end else if (ce_i) begin
         st_reg <= st_next;
         cfg_reg <= cfg_next;
         sh_reg <= sh_next;
         bits_reg <= bits_next;
         gap_reg <= gap_next;
         tied_reg <= tied_next;
         start_reg <= start_next;
         send_reg <= send_next;
         strobe_reg <= strobe_next;
         rdstb_reg <= rdstb_next;
         sdi_reg <= sdi_next;
         rdata_reg <= rdata_next;
      end
   end

   assign link.hold_start_strobe = strobe_reg;
   assign link.read_strobe = rdstb_reg;
   assign link.serial_config_input = sdi_reg;
   assign rdata_o = rdata_reg;
endmodule // dacs_ctl
`default_nettype wire

// ===== testbench/dacs_assertions.sv
// Purpose: Link timing checks between sequencer and controller
// Assumes: One clock, synchronous active-low reset, ce held high
// Notes: Sees only the link pins, so tied-strobe pairing is judged by the bench
`timescale 1ns/1ns
`default_nettype none
module dacs_assertions (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Link
   input wire logic hold_start_strobe,
   input wire logic read_strobe,
   input wire logic busy
);
   localparam int MIN_GAP = dacs_pkg::MIN_CYCLE_CLKS;
   logic [4:0] gap_reg;
   logic [4:0] gap_next;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   // Saturates so a long idle link never wraps into a false short gap
   always_comb begin
      gap_next = (gap_reg == 5'h1F) ? gap_reg : gap_reg + 5'h01;
      if (hold_start_strobe) begin
         gap_next = 5'h01;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         gap_reg <= 5'h1F;
      end else begin
         gap_reg <= gap_next;
      end
   end
   sequence busy_run;
      busy [*8] ##1 busy [*6];
   endsequence
   sequence frame_quiet;
      !read_strobe [*8] ##1 !read_strobe [*3];
   endsequence
   a_busy_on_hold: assert property (hold_start_strobe && !busy |=> busy)
      else $error("busy did not rise after the strobe");
   a_busy_span: assert property ($rose(busy) |-> busy_run ##1 !busy)
      else $error("busy span is not fourteen cycles");
   a_no_strobe_busy: assert property (busy |-> !hold_start_strobe)
      else $error("strobe raised while busy");
   a_start_gap: assert property (hold_start_strobe |-> gap_reg >= MIN_GAP)
      else $error("starts closer than sixteen clocks");
   a_cfg_frame: assert property (read_strobe |=> frame_quiet)
      else $error("read strobe broke a configuration frame");
   a_idle_low: assert property (!busy && !hold_start_strobe |=> !busy)
      else $error("busy rose without a strobe");
   a_strobe_pulse: assert property (hold_start_strobe |=> !hold_start_strobe)
      else $error("strobe longer than one cycle");
   a_acq_after: assert property ($fell(busy) |-> !busy ##1 !busy)
      else $error("acquisition shorter than two cycles");
endmodule // dacs_assertions
`default_nettype wire

// ===== testbench/testbench.sv
// Purpose: Drives the controller register port and watches both link ends
// Assumes: 10 MHz clock, reset low for five cycles
// Notes: Config timing is checked one edge before and at the apply edge
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic core_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic ce = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic pseudo = 1'b0;
   logic [11:0] samp_a = 12'h000;
   logic [11:0] samp_b = 12'h000;
   logic [15:0] rdata, d;
   logic hold, prech, neg_sel, ref_pd, valid;
   logic [1:0] pos_sel, c;
   logic [9:0] dac;
   logic [11:0] res_a, res_b;
   int n;
   int bad_count = 0;
   int total_checks = 0;
   always #50 core_clk_i = ~core_clk_i;
   dacs_link_if link ();
   dacs_dev dacs_dev_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .link(link),
      .pseudo_diff_i(pseudo), .sample_a_i(samp_a), .sample_b_i(samp_b), .hold_o(hold), .precharge_o(prech),
      .pos_sel_o(pos_sel), .neg_sel_o(neg_sel), .ref_pd_o(ref_pd), .dac_code_o(dac), .result_a_o(res_a),
      .result_b_o(res_b), .result_valid_o(valid));
   dacs_ctl dacs_ctl_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .link(link));
   dacs_assertions dacs_assertions_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
      .hold_start_strobe(link.hold_start_strobe), .read_strobe(link.read_strobe), .busy(link.busy));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [1:0] a, input logic [15:0] v);
      @(posedge core_clk_i);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge core_clk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [1:0] a, output logic [15:0] v);
      @(posedge core_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk_i);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask
   // 0 waits for read strobe, 1 for hold, 2 for result valid
   task automatic wait_for(input int which, output int cnt);
      cnt = 0;
      do begin
         @(posedge core_clk_i);
         #1;
         cnt++;
      end while (!(which == 0 ? link.read_strobe === 1'b1 : which == 1 ? hold === 1'b1 : valid === 1'b1)
         && cnt < 60);
      if (cnt >= 60) begin
         chk(16'hDEAD, 16'h0000);
      end
   endtask
   // Returns half a cycle before the word should take effect
   task automatic send_cfg(input logic [11:0] w);
      logic [11:0] got;
      int k;
      wr_reg(dacs_pkg::REG_CFG, {4'h0, w});
      wr_reg(dacs_pkg::REG_CTRL, 16'h0004);
      wait_for(0, k);
      for (int i = 0; i < 12; i++) begin
         @(negedge core_clk_i);
         got = {got[10:0], link.serial_config_input};
      end
      chk({4'h0, got}, {4'h0, w});
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      bad_count++;
      end_of_test();
   end
   initial begin
      repeat (5) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      #1;
      chk({6'h00, dac}, {6'h00, dacs_pkg::DAC_DEFAULT});
      rd_reg(2'h3, d);
      chk(d, dacs_pkg::RD_UNMAPPED);
      wr_reg(2'h3, 16'hFFFF);
      // A write while the enable is low must not land
      ce <= 1'b0;
      wr_reg(dacs_pkg::REG_CFG, 16'h0ABC);
      ce <= 1'b1;
      rd_reg(dacs_pkg::REG_CFG, d);
      chk(d, 16'h0000);
      $display("test reset done");
      send_cfg(12'h010);
      chk({15'h0000, ref_pd}, 16'h0000);
      @(posedge core_clk_i);
      #1;
      chk({15'h0000, ref_pd}, 16'h0001);
      for (int k = 0; k < 8; k++) begin
         c = 2'(k % 4);
         @(posedge core_clk_i);
         pseudo <= (k > 3);
         send_cfg({c, 10'h000});
         @(posedge core_clk_i);
         #1;
         chk({13'h0000, pos_sel, neg_sel}, {13'h0000, (c == 2'h3) ? 2'h2 : c, c == 2'h3 && k < 4});
      end
      $display("test select done");
      send_cfg(12'h001);
      repeat (2) @(posedge core_clk_i);
      send_cfg(12'h155);
      @(posedge core_clk_i);
      #1;
      chk({6'h00, dac}, 16'h0155);
      send_cfg(12'hC15);
      @(posedge core_clk_i);
      #1;
      chk({2'h0, dac, ref_pd, pos_sel, neg_sel}, 16'h3FF0);
      $display("test dac and reset done");
      @(posedge core_clk_i);
      samp_a <= 12'hABC;
      samp_b <= 12'h123;
      wr_reg(dacs_pkg::REG_CTRL, 16'h0001);
      wait_for(1, n);
      @(posedge core_clk_i);
      samp_a <= 12'h555;
      samp_b <= 12'hAAA;
      wait_for(2, n);
      chk(16'(n), 16'h000C);
      chk({res_a, res_b[11:8]}, 16'hABC1);
      chk({4'h0, res_b}, 16'h0123);
      chk({13'h0000, link.busy, hold, prech}, 16'h0007);
      @(posedge core_clk_i);
      #1;
      chk({13'h0000, link.busy, hold, prech}, 16'h0000);
      $display("test conversion done");
      // Tied starts resend the stored word, so it must not still carry the reset code
      wr_reg(dacs_pkg::REG_CFG, 16'h0000);
      wr_reg(dacs_pkg::REG_CTRL, 16'h0003);
      wr_reg(dacs_pkg::REG_CTRL, 16'h0003);
      wait_for(2, n);
      chk({4'h0, res_a}, 16'h0555);
      wait_for(0, n);
      chk({14'h0000, link.hold_start_strobe, link.read_strobe}, 16'h0003);
      rd_reg(dacs_pkg::REG_STAT, d);
      chk(d & 16'h0001, 16'h0001);
      wait_for(2, n);
      chk({4'h0, res_b}, 16'h0AAA);
      wr_reg(dacs_pkg::REG_CTRL, 16'h0000);
      $display("test tied back-to-back done");
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
